// File: hw/cim_map.svh
`ifndef CIM_MAP_SVH
`define CIM_MAP_SVH
// Width of the count register and of every stored word.
`define CIM_CNT_W      32
// Count value loaded by the arm event.
`define CIM_CNT_INIT   32'h0000_0000
// Step applied on each counted source edge.
`define CIM_CNT_STEP   32'h0000_0001
// Depth of the result buffer and its pointer width.
`define CIM_FIFO_DEPTH 16
`define CIM_FIFO_AW    4
// Positions of the pin inputs inside the synchroniser vectors.
`define CIM_PIN_N      4
`define CIM_PIN_SRC    0
`define CIM_PIN_GATE   1
`define CIM_PIN_DIR    2
`define CIM_PIN_SAMP   3
`endif

// File: hw/cim_pkg.sv
`include "cim_map.svh"
package cim_pkg;
    // Measurement selection.
    typedef enum logic [3:0] {
        CIM_EDGE_ON_DEMAND = 4'h0,
        CIM_EDGE_BUFFERED  = 4'h1,
        CIM_PW_SINGLE      = 4'h2,
        CIM_PW_IMPLICIT    = 4'h3,
        CIM_PW_SAMPLED     = 4'h4,
        CIM_PW_HW_TIMED_SINGLE_POINT = 4'h5,
        CIM_PL_SINGLE      = 4'h6,
        CIM_PL_IMPLICIT    = 4'h7,
        CIM_PL_SAMPLED     = 4'h8,
        CIM_PL_HW_TIMED_SINGLE_POINT = 4'h9
    } cim_mode_t;
    // Count direction selection.
    typedef enum logic [1:0] {
        CIM_DIR_UP   = 2'h0,
        CIM_DIR_DOWN = 2'h1,
        CIM_DIR_EXT  = 2'h2
    } cim_dir_t;
    // Sequencer states, Gray coded along idle, wait, first, second, done.
    typedef enum logic [2:0] {
        CIM_ST_IDLE  = 3'h0,
        CIM_ST_WAIT  = 3'h1,
        CIM_ST_RUN   = 3'h3,
        CIM_ST_PH2   = 3'h2,
        CIM_ST_DONE  = 3'h6
    } cim_state_t;
    // Complete state of the measurement core.
    typedef struct packed {
        logic [`CIM_PIN_N-1:0] syncA;
        logic [`CIM_PIN_N-1:0] syncB;
        logic [`CIM_PIN_N-1:0] prevB;
        cim_state_t            state;
        logic [`CIM_CNT_W-1:0] count;
        logic [`CIM_CNT_W-1:0] widthHi;
        logic [`CIM_CNT_W-1:0] widthLo;
        logic                  fresh;
        logic                  pendValid;
        logic [`CIM_CNT_W-1:0] pendData;
        logic                  pushValid;
        logic [`CIM_CNT_W-1:0] pushData;
        logic                  overrun;
        logic                  dataLost;
    } cim_core_t;
endpackage : cim_pkg

// File: hw/cim_top.sv
`timescale 1ns/1ps
`include "cim_map.svh"
// Operation
// (RULE1) Armed counter steps on selected source edge.
// (RULE2) Count output readable anytime without disturbing counting.
// (RULE3) Active pause trigger makes source edges ignored.
// (RULE4) Pause comes from gate, polarity selectable.
// (RULE5) Sample edge captures running count into buffer.
// (RULE6) Samples cumulative since arm, never cleared.
// (RULE7) Sample clock edge selectable rising or falling.
// (RULE8) Direction up, down, or from direction pin.
// (RULE9) Pulse width measures high or low pulses.
// (RULE10) Count source edges only while gate active.
// (RULE11) Armed inside active pulse waits next leading.
// (RULE12) Single width stored at trailing, then stop.
// (RULE13) Implicit width stores each trailing edge count.
// (RULE14) Sample edge stores last completed pulse width.
// (RULE15) Timed single point flags overrun without pulse.
// (RULE16) Pulse measures both active and inactive phases.
// (RULE17) Single pulse equals two consecutive width measurements.
// (RULE18) Implicit pulse stores count on every gate edge.
// (RULE19) First phase select picks starting gate edge.
// (RULE20) Sample edge stores high and low counts.
// (RULE21) Timed single point pulse flags overrun too.
// (RULE22) External DMA drains the result buffer.
// (RULE23) Count and stored words are 32 bits.
// (RULE24) Arm clears count and previous measurement state.

// Result buffer; output word is registered so the drain sees flop data.
module cim_fifo #(
    parameter int WIDTH = `CIM_CNT_W,
    parameter int DEPTH = `CIM_FIFO_DEPTH,
    parameter int AW    = `CIM_FIFO_AW
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    output logic                  outValid,
    output logic      [WIDTH-1:0] outData,
    input  wire logic             outReady
);
    typedef struct packed {
        logic [AW:0]      used;
        logic [AW-1:0]    wrPtr;
        logic [AW-1:0]    rdPtr;
        logic             outValid;
        logic [WIDTH-1:0] outData;
    } cim_fifo_t;

    localparam logic [AW:0] FULL_LVL = (AW+1)'(DEPTH);
    localparam logic [AW:0] ONE_LVL  = (AW+1)'(1);

    logic [WIDTH-1:0] mem [DEPTH];
    cim_fifo_t        fifo_reg;
    cim_fifo_t        fifo_next;
    logic             doPush;
    logic             doPop;

    // Full is honest: the source sees back-pressure once all slots hold data.
    assign inReady = (fifo_reg.used != FULL_LVL);
    assign doPush  = inValid && inReady;
    assign doPop   = (fifo_reg.used != '0)
                     && (!fifo_reg.outValid || outReady);

    // Pointer and output stage update.
    always_comb begin
        fifo_next = fifo_reg;
        if (fifo_reg.outValid && outReady) begin
            fifo_next.outValid = 1'b0;
        end
        if (doPop) begin
            fifo_next.outData  = mem[fifo_reg.rdPtr];
            fifo_next.outValid = 1'b1;
            fifo_next.rdPtr    = fifo_reg.rdPtr + 1'b1;
        end
        if (doPush) begin
            fifo_next.wrPtr = fifo_reg.wrPtr + 1'b1;
        end
        if (doPush && !doPop) begin
            fifo_next.used = fifo_reg.used + ONE_LVL;
        end else if (!doPush && doPop) begin
            fifo_next.used = fifo_reg.used - ONE_LVL;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fifo_reg <= '0;
        end else begin
            fifo_reg <= fifo_next;
        end
    end

    // Storage has no reset; only slots behind the write pointer are read.
    always_ff @(posedge clk_sys) begin
        if (doPush) begin
            mem[fifo_reg.wrPtr] <= inData;
        end
    end

    assign outValid = fifo_reg.outValid;
    assign outData  = fifo_reg.outData;
endmodule : cim_fifo

module cim_top
    import cim_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  srcPin,
    input  wire logic                  gatePin,
    input  wire logic                  dirPin,
    input  wire logic                  sampleClkPin,
    input  wire logic                  armStart,
    input  wire cim_mode_t             measMode,
    input  wire cim_dir_t              dirMode,
    input  wire logic                  srcFallEdge,
    input  wire logic                  sampleFallEdge,
    input  wire logic                  pauseEnable,
    input  wire logic                  pauseWhenHigh,
    input  wire logic                  measureLowPulse,
    input  wire logic                  firstPhaseSelect,
    output logic [`CIM_CNT_W-1:0]      countValue,
    output logic                       overrunError,
    output logic                       dataLost,
    output logic                       fifoOutValid,
    output logic [`CIM_CNT_W-1:0]      fifoOutData,
    input  wire logic                  fifoOutReady
);
    cim_core_t             core_reg;
    cim_core_t             core_next;
    logic                  fifoInReady;
    logic                  srcHit;
    logic                  sampHit;
    logic                  paused;
    logic                  countUp;
    logic                  actNow;
    logic                  actPrev;
    logic                  gateEdge;
    logic                  startEdge;
    logic                  isEdge;
    logic                  isPw;
    logic                  isSampled;
    logic                  isHwtsp;
    logic                  doPush;
    logic [`CIM_CNT_W-1:0] pushWord;

    // Selected transition between two synchronised samples.
    function automatic logic edgeHit(input logic prv, input logic cur,
                                     input logic fall);
        edgeHit = fall ? (prv && !cur) : (!prv && cur);
    endfunction : edgeHit

    // Decoded view of the synchronised pins and the mode.
    always_comb begin
        srcHit  = edgeHit(core_reg.prevB[`CIM_PIN_SRC],
                          core_reg.syncB[`CIM_PIN_SRC], srcFallEdge); // RULE1
        sampHit = edgeHit(core_reg.prevB[`CIM_PIN_SAMP],
                          core_reg.syncB[`CIM_PIN_SAMP],
                          sampleFallEdge); // RULE7
        paused  = pauseEnable
                  && (core_reg.syncB[`CIM_PIN_GATE] == pauseWhenHigh); // RULE4
        countUp = (dirMode == CIM_DIR_UP)
                  || ((dirMode == CIM_DIR_EXT)
                      && core_reg.syncB[`CIM_PIN_DIR]); // RULE8
        actNow  = core_reg.syncB[`CIM_PIN_GATE] ^ measureLowPulse; // RULE9
        actPrev = core_reg.prevB[`CIM_PIN_GATE] ^ measureLowPulse;
        gateEdge  = core_reg.syncB[`CIM_PIN_GATE]
                    != core_reg.prevB[`CIM_PIN_GATE];
        startEdge = edgeHit(core_reg.prevB[`CIM_PIN_GATE],
                            core_reg.syncB[`CIM_PIN_GATE],
                            firstPhaseSelect); // RULE19
        isEdge    = (measMode == CIM_EDGE_ON_DEMAND)
                    || (measMode == CIM_EDGE_BUFFERED);
        isPw      = (measMode >= CIM_PW_SINGLE)
                    && (measMode <= CIM_PW_HW_TIMED_SINGLE_POINT);
        isHwtsp   = (measMode == CIM_PW_HW_TIMED_SINGLE_POINT)
                    || (measMode == CIM_PL_HW_TIMED_SINGLE_POINT);
        isSampled = isHwtsp || (measMode == CIM_PW_SAMPLED)
                    || (measMode == CIM_PL_SAMPLED);
    end

    // Whole core next state. Pins pass two flops before any decode.
    always_comb begin
        core_next       = core_reg;
        doPush          = 1'b0;
        pushWord        = core_reg.count;
        core_next.syncA = {sampleClkPin, dirPin, gatePin, srcPin};
        core_next.syncB = core_reg.syncA;
        core_next.prevB = core_reg.syncB;
        core_next.pushValid = 1'b0;
        // A word refused by a full buffer is dropped and remembered.
        if (core_reg.pushValid && !fifoInReady) begin
            core_next.dataLost = 1'b1;
        end
        if (armStart) begin
            core_next.count     = `CIM_CNT_INIT; // RULE24
            core_next.widthHi   = `CIM_CNT_INIT;
            core_next.widthLo   = `CIM_CNT_INIT;
            core_next.fresh     = 1'b0;
            core_next.pendValid = 1'b0;
            core_next.overrun   = 1'b0;
            core_next.dataLost  = 1'b0;
            core_next.state     = isEdge ? CIM_ST_RUN : CIM_ST_WAIT; // RULE11
        end else begin
            // Sample edges report the last finished result.
            if (isSampled && sampHit && core_reg.state != CIM_ST_IDLE) begin
                doPush   = 1'b1;
                pushWord = core_reg.widthHi; // RULE14
                if (!isPw) begin
                    core_next.pendValid = 1'b1; // RULE20
                    core_next.pendData  = core_reg.widthLo;
                end
                if (isHwtsp && !core_reg.fresh) begin
                    core_next.overrun = 1'b1; // RULE15 RULE21
                end
                core_next.fresh = 1'b0;
            end
            case (core_reg.state)
                CIM_ST_RUN: begin
                    if (isEdge) begin
                        if (srcHit && !paused) begin // RULE3
                            core_next.count = countUp
                                ? core_reg.count + `CIM_CNT_STEP
                                : core_reg.count - `CIM_CNT_STEP; // RULE1
                        end
                        if (measMode == CIM_EDGE_BUFFERED && sampHit) begin
                            doPush   = 1'b1; // RULE5 RULE6
                            pushWord = core_reg.count;
                        end
                    end else if (isPw) begin
                        if (actPrev && !actNow) begin
                            core_next.count = `CIM_CNT_INIT;
                            core_next.state = CIM_ST_WAIT;
                            if (isSampled) begin
                                core_next.widthHi = core_reg.count;
                                core_next.fresh   = 1'b1;
                            end else begin
                                doPush   = 1'b1; // RULE13
                                pushWord = core_reg.count;
                                if (measMode == CIM_PW_SINGLE) begin
                                    core_next.state = CIM_ST_DONE; // RULE12
                                end
                            end
                        end else if (srcHit && actNow) begin
                            core_next.count = core_reg.count
                                              + `CIM_CNT_STEP; // RULE10
                        end
                    end else begin
                        // First phase of a pulse measurement.
                        if (gateEdge) begin
                            core_next.count = `CIM_CNT_INIT;
                            core_next.state = CIM_ST_PH2; // RULE16
                            if (isSampled) begin
                                if (firstPhaseSelect) begin
                                    core_next.widthLo = core_reg.count;
                                end else begin
                                    core_next.widthHi = core_reg.count;
                                end
                            end else begin
                                doPush   = 1'b1; // RULE18
                                pushWord = core_reg.count;
                            end
                        end else if (srcHit) begin
                            core_next.count = core_reg.count
                                              + `CIM_CNT_STEP;
                        end
                    end
                end
                CIM_ST_PH2: begin
                    // Second phase; a pair is complete at its end.
                    if (gateEdge) begin
                        core_next.count = `CIM_CNT_INIT;
                        core_next.state = CIM_ST_RUN;
                        if (isSampled) begin
                            if (firstPhaseSelect) begin
                                core_next.widthHi = core_reg.count;
                            end else begin
                                core_next.widthLo = core_reg.count;
                            end
                            core_next.fresh = 1'b1;
                        end else begin
                            doPush   = 1'b1; // RULE18
                            pushWord = core_reg.count;
                            if (measMode == CIM_PL_SINGLE) begin
                                core_next.state = CIM_ST_DONE; // RULE17
                            end
                        end
                    end else if (srcHit) begin
                        core_next.count = core_reg.count + `CIM_CNT_STEP;
                    end
                end
                CIM_ST_WAIT: begin
                    // A pulse already in progress is skipped.
                    if (isPw ? (actNow && !actPrev) : startEdge) begin
                        core_next.count = `CIM_CNT_INIT; // RULE11
                        core_next.state = CIM_ST_RUN;
                    end
                end
                CIM_ST_IDLE: begin
                    core_next.state = CIM_ST_IDLE;
                end
                CIM_ST_DONE: begin
                    core_next.state = CIM_ST_DONE; // RULE12
                end
                default: begin
                    core_next.state = CIM_ST_IDLE;
                end
            endcase
        end
        // Sample edges are two cycles apart at least, so the second word
        // of a pair never meets a new push.
        if (doPush) begin
            core_next.pushValid = 1'b1;
            core_next.pushData  = pushWord;
        end else if (core_reg.pendValid && !armStart) begin
            core_next.pushValid = 1'b1;
            core_next.pushData  = core_reg.pendData;
            core_next.pendValid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            core_reg <= '0;
        end else begin
            core_reg <= core_next;
        end
    end

    // The drain side stalls the buffer; overflow shows on dataLost.
    cim_fifo #(
        .WIDTH (`CIM_CNT_W),
        .DEPTH (`CIM_FIFO_DEPTH),
        .AW    (`CIM_FIFO_AW)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .inValid  (core_reg.pushValid),
        .inData   (core_reg.pushData),
        .inReady  (fifoInReady),
        .outValid (fifoOutValid),
        .outData  (fifoOutData),
        .outReady (fifoOutReady) // RULE22
    );

    // Count is a plain register read; reading never touches it.
    assign countValue   = core_reg.count; // RULE2 RULE23
    assign overrunError = core_reg.overrun;
    assign dataLost     = core_reg.dataLost;

    sequence s_trail;
        core_reg.state == CIM_ST_RUN && isPw && actPrev && !actNow;
    endsequence
    sequence s_pair_out;
        core_reg.pushValid ##1 core_reg.pushValid;
    endsequence

    a_arm_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
        armStart |=> core_reg.count == `CIM_CNT_INIT && !core_reg.overrun)
        else $error("arm did not clear"); // RULE24
    a_count_step_up: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core_reg.state == CIM_ST_RUN && isEdge && srcHit && !paused
        && countUp && !armStart
        |=> core_reg.count == $past(core_reg.count) + `CIM_CNT_STEP)
        else $error("missed up step"); // RULE1
    a_count_step_dn: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core_reg.state == CIM_ST_RUN && isEdge && srcHit && !paused
        && !countUp && !armStart
        |=> core_reg.count == $past(core_reg.count) - `CIM_CNT_STEP)
        else $error("missed down step"); // RULE8
    a_pause_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core_reg.state == CIM_ST_RUN && isEdge && paused && !armStart
        |=> $stable(core_reg.count))
        else $error("count moved while paused"); // RULE3
    a_buf_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core_reg.state == CIM_ST_RUN && measMode == CIM_EDGE_BUFFERED
        && sampHit && !armStart
        |=> core_reg.pushValid
            && core_reg.pushData == $past(core_reg.count))
        else $error("sample not captured"); // RULE5
    a_no_reload: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core_reg.state == CIM_ST_RUN && isEdge && sampHit && !srcHit
        && !armStart |=> $stable(core_reg.count))
        else $error("sample edge changed count"); // RULE6
    a_wait_idle_cnt: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core_reg.state == CIM_ST_WAIT && !armStart |=> core_reg.count == '0)
        else $error("counted before leading edge"); // RULE11
    a_trail_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_trail ##0 (!isSampled && !armStart)
        |=> core_reg.pushValid
            && core_reg.pushData == $past(core_reg.count))
        else $error("trailing edge not stored"); // RULE13
    a_single_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core_reg.state == CIM_ST_DONE && !armStart
        |=> core_reg.state == CIM_ST_DONE && $stable(core_reg.count))
        else $error("single measurement resumed"); // RULE12
    a_overrun_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        isHwtsp && sampHit && !core_reg.fresh && !armStart
        && core_reg.state != CIM_ST_IDLE |=> core_reg.overrun)
        else $error("overrun not flagged"); // RULE15
    a_pulse_pair: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (measMode == CIM_PL_SAMPLED) && sampHit && !armStart
        && core_reg.state != CIM_ST_IDLE
        |=> s_pair_out ##0 core_reg.pushData == $past(core_reg.widthLo, 2))
        else $error("pair not emitted"); // RULE20
endmodule : cim_top

// File: verif/cim_far_side.sv
`timescale 1ns/1ps
// Stand-in for the source generator and the DMA drain.
module cim_far_side (
    input  wire logic        clk_sys,
    output logic             srcPin,
    output logic             fifoOutReady,
    input  wire logic        fifoOutValid,
    input  wire logic [31:0] fifoOutData
);
    logic [31:0] words[$];
    logic        stall = 1'b0;
    initial srcPin = 1'b0;
    // A stalled drain lets the buffer fill up.
    assign fifoOutReady = !stall;
    // Each accepted word goes to the host copy.
    always @(posedge clk_sys) begin
        if (fifoOutValid && fifoOutReady) words.push_back(fifoOutData);
    end
    // Each level lasts two clocks, else the synchroniser may miss it.
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            srcPin <= 1'b1;
            repeat (2) @(posedge clk_sys);
            srcPin <= 1'b0;
            @(posedge clk_sys);
        end
    endtask : pulses
endmodule : cim_far_side

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import cim_pkg::*;
    logic        clk_sys = 0, rst_n = 0, gatePin = 0, samp = 0, arm_ = 0;
    logic        pauseEn = 0, pauseHi = 0, srcPin, rdy, vld;
    logic        ovr, lost, dirP = 0, srcFall = 0, sampFall = 0;
    logic        lowPulse = 0, firstPh = 0;
    logic [31:0] cnt, data;
    cim_mode_t   mode = CIM_EDGE_ON_DEMAND;
    cim_dir_t    dir = CIM_DIR_UP;
    int          bad_count = 0, total_checks = 0;
    cim_top i_cim_top (.clk_sys(clk_sys), .rst_n(rst_n), .srcPin(srcPin),
        .gatePin(gatePin), .dirPin(dirP), .sampleClkPin(samp),
        .armStart(arm_), .measMode(mode), .dirMode(dir),
        .srcFallEdge(srcFall), .sampleFallEdge(sampFall),
        .pauseEnable(pauseEn),
        .pauseWhenHigh(pauseHi), .measureLowPulse(lowPulse),
        .firstPhaseSelect(firstPh), .countValue(cnt), .overrunError(ovr),
        .dataLost(lost), .fifoOutValid(vld), .fifoOutData(data),
        .fifoOutReady(rdy));
    cim_far_side i_cim_far_side (.clk_sys(clk_sys), .srcPin(srcPin),
        .fifoOutReady(rdy), .fifoOutValid(vld), .fifoOutData(data));
    // The clock runs at 10 MHz.
    initial forever #50 clk_sys = ~clk_sys;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc
    task automatic arm(input cim_mode_t m);
        mode <= m;
        arm_ <= 1'b1;
        cyc(1);
        arm_ <= 1'b0;
        cyc(2);
    endtask : arm
    task automatic gate(input logic v);
        cyc(4);
        gatePin <= v;
        cyc(4);
    endtask : gate
    task automatic sample();
        samp <= 1'b1;
        cyc(3);
        samp <= 1'b0;
        cyc(3);
    endtask : sample
    // Compares the drained words with the expected list, then clears the drained words.
    task automatic got(input logic [31:0] e[$]);
        cyc(6);
        chk(i_cim_far_side.words.size(), e.size());
        foreach (e[i]) chk(i_cim_far_side.words[i], e[i]);
        i_cim_far_side.words.delete();
    endtask : got
    task automatic t_edge();
        arm(CIM_EDGE_ON_DEMAND);
        i_cim_far_side.pulses(5);
        cyc(6);
        chk(cnt, 32'h0000_0005);
        dir <= CIM_DIR_DOWN;
        i_cim_far_side.pulses(2);
        cyc(6);
        chk(cnt, 32'h0000_0003);
        pauseEn <= 1'b1;
        pauseHi <= 1'b1;
        gate(1'b1);
        i_cim_far_side.pulses(3);
        cyc(6);
        chk(cnt, 32'h0000_0003);
        gate(1'b0);
        i_cim_far_side.pulses(1);
        cyc(6);
        chk(cnt, 32'h0000_0002);
        pauseHi <= 1'b0;
        i_cim_far_side.pulses(1);
        cyc(6);
        chk(cnt, 32'h0000_0002);
        pauseEn <= 1'b0;
        dir <= CIM_DIR_EXT;
        dirP <= 1'b1;
        srcFall <= 1'b1;
        i_cim_far_side.pulses(2);
        cyc(6);
        chk(cnt, 32'h0000_0004);
        dirP <= 1'b0;
        i_cim_far_side.pulses(1);
        cyc(6);
        chk(cnt, 32'h0000_0003);
        srcFall <= 1'b0;
        dir <= CIM_DIR_UP;
    endtask : t_edge
    task automatic t_buf();
        arm(CIM_EDGE_BUFFERED);
        i_cim_far_side.pulses(3);
        cyc(6);
        sample();
        i_cim_far_side.pulses(2);
        cyc(6);
        sampFall <= 1'b1;
        sample();
        got('{32'h0000_0003, 32'h0000_0005});
        sampFall <= 1'b0;
        i_cim_far_side.stall <= 1'b1;
        arm(CIM_EDGE_BUFFERED);
        repeat (18) sample();
        chk(lost, 1'b1);
        i_cim_far_side.stall <= 1'b0;
        cyc(30);
        chk(i_cim_far_side.words.size(), 17);
        i_cim_far_side.words.delete();
    endtask : t_buf
    task automatic t_pw();
        gate(1'b1);
        arm(CIM_PW_SINGLE);
        i_cim_far_side.pulses(2);
        gate(1'b0);
        gate(1'b1);
        i_cim_far_side.pulses(4);
        gate(1'b0);
        i_cim_far_side.pulses(2);
        gate(1'b1);
        i_cim_far_side.pulses(1);
        gate(1'b0);
        got('{32'h0000_0004});
        arm(CIM_PL_IMPLICIT);
        i_cim_far_side.pulses(2);
        gate(1'b1);
        i_cim_far_side.pulses(3);
        gate(1'b0);
        i_cim_far_side.pulses(2);
        gate(1'b1);
        got('{32'h0000_0003, 32'h0000_0002});
        gate(1'b0);
        arm(CIM_PW_HW_TIMED_SINGLE_POINT);
        chk(ovr, 1'b0);
        sample();
        sample();
        chk(ovr, 1'b1);
        got('{32'h0000_0000, 32'h0000_0000,
              32'h0000_0000});
    endtask : t_pw
    // Low pulses, sampled reports and low-first pulse pairs.
    task automatic t_smp();
        lowPulse <= 1'b1;
        arm(CIM_PW_IMPLICIT);
        gate(1'b1);
        gate(1'b0);
        i_cim_far_side.pulses(2);
        gate(1'b1);
        got('{32'h0000_0002});
        arm(CIM_PW_SAMPLED);
        gate(1'b0);
        i_cim_far_side.pulses(3);
        gate(1'b1);
        sample();
        got('{32'h0000_0003});
        firstPh <= 1'b1;
        arm(CIM_PL_SAMPLED);
        gate(1'b0);
        i_cim_far_side.pulses(2);
        gate(1'b1);
        i_cim_far_side.pulses(3);
        gate(1'b0);
        sample();
        got('{32'h0000_0003, 32'h0000_0002});
        arm(CIM_PL_HW_TIMED_SINGLE_POINT);
        gate(1'b1);
        gate(1'b0);
        i_cim_far_side.pulses(1);
        gate(1'b1);
        gate(1'b0);
        sample();
        chk(ovr, 1'b0);
        sample();
        chk(ovr, 1'b1);
        got('{32'h0000_0000, 32'h0000_0001,
              32'h0000_0000, 32'h0000_0001});
        arm(CIM_PL_SINGLE);
        gate(1'b1);
        gate(1'b0);
        i_cim_far_side.pulses(1);
        gate(1'b1);
        i_cim_far_side.pulses(2);
        gate(1'b0);
        i_cim_far_side.pulses(1);
        got('{32'h0000_0001, 32'h0000_0002});
    endtask : t_smp
    // Reset is held for 16 clocks before the scenarios run.
    initial begin
        cyc(16);
        rst_n <= 1'b1;
        cyc(2);
        t_edge();
        t_buf();
        t_pw();
        t_smp();
        report_and_stop();
    end
    // The scenarios need well under 2000 clocks.
    initial begin
        cyc(6000);
        bad_count++;
        report_and_stop();
    end
endmodule : tb_top
